// [rtl/adc_seq_pkg.sv]
`default_nettype none

package adc_seq_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and timing figures
  localparam int unsigned CLK_PERIOD_NS   = 5;
  localparam int unsigned CYCLE_CLKS      = 40002;  // Continuous cycle, input start to input start
  localparam int unsigned INPUT_INT_CLKS  = 10000;  // Fixed signal integration
  localparam int unsigned AUTOZERO_CLKS   = 10001;  // System zero of a commanded cycle
  localparam int unsigned REF_MAX_CLKS    = 20001;  // Reference window; reaching it is overrange
  localparam int unsigned OVERRANGE_LIMIT = 20000;  // Counts above this are overrange
  localparam int unsigned IZ_NORMAL_CLKS  = 150;    // Integrator zero, inside 100 to 200
  localparam int unsigned IZ_OVER_CLKS    = 6200;   // Integrator zero after overrange
  localparam int unsigned TOP_DIGIT_CLKS  = 201;
  localparam int unsigned DIGIT_CLKS      = 200;
  localparam int unsigned STROBE_OFFSET   = 100;    // Select rise to strobe
  localparam int unsigned RUN_PULSE_NS    = 300;    // Run pulse must be wider than this
  localparam int unsigned RUN_PULSE_CLKS  = (RUN_PULSE_NS + CLK_PERIOD_NS) / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////////
  // Widths and reset values
  localparam int unsigned CNT_W       = 16;
  localparam int unsigned SCAN_CNT_W  = 8;
  localparam int unsigned RUN_CNT_W   = 7;
  localparam int unsigned DIGITS      = 5;
  localparam int unsigned READING_W   = 20;
  localparam int unsigned TOP_IDX     = 0;
  localparam int unsigned LAST_IDX    = 4;
  localparam logic [19:0] READING_RST = 20'h00000;
  localparam logic [4:0]  SEL_TOP     = 5'h10;

  typedef enum logic [2:0] {
    PH_SYS_ZERO,
    PH_INPUT,
    PH_REF,
    PH_INT_ZERO,
    PH_HOLD
  } phase_t;

  // Adds one to a five digit BCD number
  function automatic logic [19:0] bcd_inc(input logic [19:0] v);
    logic [19:0] r;
    logic        carry;
    r     = v;
    carry = 1'b1;
    for (int i = 0; i < 5; i++) begin
      if (carry) begin
        if (r[i*4 +: 4] == 4'h9) begin
          r[i*4 +: 4] = 4'h0;
        end else begin
          r[i*4 +: 4] = r[i*4 +: 4] + 4'h1;
          carry       = 1'b0;
        end
      end
    end
    return r;
  endfunction

endpackage

`default_nettype wire

// [rtl/digit_scan.sv]
`timescale 1ns/10ps
`default_nettype none

module digit_scan (
  input wire logic clk_sys,
  input wire logic rst_n,
  scan_if.scan     link
);
  import adc_seq_pkg::*;

  typedef struct packed {
    logic [19:0]           digits;
    logic                  over;
    logic                  blank;
    logic                  strobing;
    logic                  active;
    logic [2:0]            idx;
    logic [SCAN_CNT_W-1:0] cnt;
    logic [4:0]            sel;
    logic [3:0]            bcd;
    logic                  strobe_n;
  } scan_state_t;

  scan_state_t s;
  scan_state_t next_s;
  logic        last_cnt;

  ////////////////////////////////////////////////////////////////////////////////
  // Scan walk: top digit first, then down to the least significant
  always_comb begin
    next_s          = s;
    next_s.strobe_n = 1'b1;
    last_cnt        = (s.idx == 3'(TOP_IDX)) ? (s.cnt == SCAN_CNT_W'(TOP_DIGIT_CLKS - 1))  // RL15
                                             : (s.cnt == SCAN_CNT_W'(DIGIT_CLKS - 1));     // RL16
    if (link.load) begin
      next_s.digits   = link.reading;
      next_s.over     = link.over;
      next_s.blank    = 1'b0;
      next_s.strobing = 1'b1;                  // RL14
      next_s.active   = 1'b1;
      next_s.idx      = 3'(TOP_IDX);
      next_s.cnt      = '0;
    end else if (s.blank) begin
      // Held dark until the next reference phase, which gives the blinking
      if (link.resume) begin
        next_s.blank = 1'b0;
        next_s.idx   = 3'(TOP_IDX);
        next_s.cnt   = '0;
      end
    end else if (s.active) begin
      if (last_cnt) begin
        next_s.cnt = '0;
        if (s.idx == 3'(LAST_IDX)) begin
          next_s.idx      = 3'(TOP_IDX);
          next_s.strobing = 1'b0;              // RL17
          next_s.blank    = s.over;            // RL18
        end else begin
          next_s.idx = s.idx + 3'h1;
        end
      end else begin
        next_s.cnt = s.cnt + SCAN_CNT_W'(1);
      end
    end
    // Strobe one clock, centred in the select; selects and data change together
    if (next_s.strobing && next_s.active && !next_s.blank && !link.load &&
        next_s.cnt == SCAN_CNT_W'(STROBE_OFFSET)) begin
      next_s.strobe_n = 1'b0;                  // RL14
    end
    if (next_s.active && !next_s.blank) begin
      next_s.sel = SEL_TOP >> next_s.idx;      // RL23
      next_s.bcd = next_s.over ? 4'h0 : next_s.digits[(4 - int'(next_s.idx))*4 +: 4];  // RL23
    end else begin
      next_s.sel = 5'h00;
      next_s.bcd = 4'h0;
    end
  end

  // Idle and dark until the first measurement completes
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s          <= '0;
      s.strobe_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign link.digit_sel = s.sel;
  assign link.bcd       = s.bcd;
  assign link.strobe_n  = s.strobe_n;

endmodule // digit_scan

`default_nettype wire

// [rtl/dual_slope_adc_sequencer.sv]
//Behaviour
//RL1 - Cycle runs system zero, input integration, reference integration, integrator zero, in order
//RL2 - Switches per phase: input only; one reference plus loop; loop plus integrator zero
//RL3 - System zero opens inputs, closes zeroing, reference charge and loop switches
//RL4 - Input integration ends on a fixed clock count, never on analog state
//RL5 - Input polarity is latched when input integration ends
//RL6 - Reference opposite to latched polarity, integrate until comparator reports zero
//RL7 - Reading is the count of reference integration clocks
//RL8 - Integrator zero lasts 100 to 200 clocks, 6200 after overrange
//RL9 - Run/hold reads high when open; high means a cycle every 40002 clocks
//RL10 - Run/hold low finishes current cycle, then holds and shows the result
//RL11 - In hold a run pulse over 300 ns starts exactly one cycle
//RL12 - Run pulses are ignored until the interrupted cycle has completed
//RL13 - Commanded cycle starts with 10001 clock auto-zero; busy rises at its end
//RL14 - Five low strobe pulses per measurement, centred in each digit select
//RL15 - Top digit select high 201 clocks; first strobe 101 clocks after end
//RL16 - Following selects high 200 clocks; strobe 100 clocks after each rise
//RL17 - Selects keep refreshing after the scan, strobes wait for a new result
//RL18 - After overrange the digit scan stops instead of refreshing
//RL19 - Receiver captures the BCD digit on each low strobe
//RL20 - Busy high from input integration start until the clock after zero crossing
//RL21 - Overrange set as busy falls past 20000 clocks, cleared at next reference
//RL22 - Polarity is 1 for positive, valid from reference start until redetermined
//RL23 - BCD positive true, changes with selects, zero under overrange
//RL24 - Input integration 10000 clocks, reference gets the rest of the cycle; code caps reference at 20001 and stretches system zero to fill it
`timescale 1ns/10ps
`default_nettype none

module dual_slope_adc_sequencer #(
  parameter int unsigned CYCLE_LEN    = adc_seq_pkg::CYCLE_CLKS,
  parameter int unsigned INPUT_LEN    = adc_seq_pkg::INPUT_INT_CLKS,
  parameter int unsigned AUTOZERO_LEN = adc_seq_pkg::AUTOZERO_CLKS,
  parameter int unsigned REF_MAX_LEN  = adc_seq_pkg::REF_MAX_CLKS,
  parameter int unsigned IZ_OVER_LEN  = adc_seq_pkg::IZ_OVER_CLKS
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       run_hold,
  input  wire logic       integrator_at_zero,
  input  wire logic       input_positive,
  output var  logic       input_switch,
  output var  logic       ref_plus_switch,
  output var  logic       ref_minus_switch,
  output var  logic       zeroing_switch,
  output var  logic       reference_charge_switch,
  output var  logic       integrator_loop_switch,
  output var  logic       integrator_zero_switch,
  output var  logic       busy,
  output var  logic       overrange,
  output var  logic       polarity,
  output var  logic [4:0] digit_select,
  output var  logic [3:0] bcd,
  output var  logic       strobe_n
);
  import adc_seq_pkg::*;

  typedef struct packed {
    phase_t                phase;
    logic [CNT_W-1:0]      cnt;
    logic [CNT_W-1:0]      frame;
    logic                  commanded;
    logic [READING_W-1:0]  reading;
    logic                  busy;
    logic                  over;
    logic                  pol;
    logic                  load;
    logic                  resume;
    logic                  sw_input;
    logic                  sw_ref_plus;
    logic                  sw_ref_minus;
    logic                  sw_zeroing;
    logic                  sw_ref_charge;
    logic                  sw_loop;
    logic                  sw_int_zero;
  } seq_state_t;

  seq_state_t       s;
  seq_state_t       next_s;
  logic             run_level;
  logic             run_pulse;
  logic [CNT_W-1:0] iz_last;

  scan_if scan_bus ();

  ////////////////////////////////////////////////////////////////////////////////
  // Run/hold width filter
  run_hold_filter u_run_filter (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .run_hold  (run_hold),
    .run_level (run_level),
    .run_pulse (run_pulse)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Digit drive, BCD and strobe generation
  digit_scan u_digit_scan (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .link    (scan_bus.scan)
  );

  assign scan_bus.load    = s.load;
  assign scan_bus.reading = s.reading;
  assign scan_bus.over    = s.over;
  assign scan_bus.resume  = s.resume;

  ////////////////////////////////////////////////////////////////////////////////
  // Phase sequencer
  always_comb begin
    next_s        = s;
    next_s.load   = 1'b0;
    next_s.resume = 1'b0;
    next_s.cnt    = s.cnt + CNT_W'(1);
    // Frame counts from input start; saturating keeps a long hold harmless
    next_s.frame  = (s.frame == '1) ? s.frame : s.frame + CNT_W'(1);
    iz_last       = s.over ? CNT_W'(IZ_OVER_LEN - 1) : CNT_W'(IZ_NORMAL_CLKS - 1);  // RL8
    case (s.phase)
      PH_SYS_ZERO: begin
        // Continuous cycles stretch system zero so input starts land 40002 apart
        if ((s.commanded && s.cnt >= CNT_W'(AUTOZERO_LEN - 1)) ||      // RL13
            (!s.commanded && s.frame >= CNT_W'(CYCLE_LEN - 1))) begin  // RL9 RL24
          next_s.phase     = PH_INPUT;  // RL1
          next_s.cnt       = '0;
          next_s.frame     = '0;
          next_s.commanded = 1'b0;
          next_s.busy      = 1'b1;      // RL20 RL13
        end
      end
      PH_INPUT: begin
        // Length is a pure clock count; the comparator is not looked at here
        if (s.cnt == CNT_W'(INPUT_LEN - 1)) begin  // RL4 RL24
          next_s.phase   = PH_REF;                 // RL1
          next_s.cnt     = '0;
          next_s.pol     = input_positive;         // RL5 RL22
          next_s.over    = 1'b0;                   // RL21
          next_s.reading = READING_RST;
          next_s.resume  = 1'b1;
        end
      end
      PH_REF: begin
        if (integrator_at_zero) begin              // RL6
          next_s.phase = PH_INT_ZERO;              // RL1
          next_s.cnt   = '0;
          next_s.busy  = 1'b0;                     // RL20
          next_s.load  = 1'b1;
        end else if (s.cnt == CNT_W'(REF_MAX_LEN - 1)) begin
          // No crossing within the window: more than 20000 counts
          next_s.phase = PH_INT_ZERO;
          next_s.cnt   = '0;
          next_s.busy  = 1'b0;                     // RL20
          next_s.over  = 1'b1;                     // RL21
          next_s.load  = 1'b1;
        end else begin
          next_s.reading = bcd_inc(s.reading);     // RL7
        end
      end
      PH_INT_ZERO: begin
        if (s.cnt >= iz_last) begin                // RL8
          next_s.cnt = '0;
          if (run_level) begin
            next_s.phase = PH_SYS_ZERO;            // RL1 RL9
          end else begin
            next_s.phase = PH_HOLD;                // RL10
          end
        end
      end
      PH_HOLD: begin
        // Pulses only count here, so one seen mid-cycle never starts a second cycle
        if (run_pulse) begin                       // RL11 RL12
          next_s.phase     = PH_SYS_ZERO;
          next_s.commanded = 1'b1;                 // RL13
          next_s.cnt       = '0;
        end
      end
      default: begin
        next_s.phase = PH_HOLD;
      end
    endcase

    // Switch controls follow the phase being entered
    next_s.sw_input      = 1'b0;
    next_s.sw_ref_plus   = 1'b0;
    next_s.sw_ref_minus  = 1'b0;
    next_s.sw_zeroing    = 1'b0;
    next_s.sw_ref_charge = 1'b0;
    next_s.sw_loop       = 1'b0;
    next_s.sw_int_zero   = 1'b0;
    case (next_s.phase)
      PH_INPUT: begin
        next_s.sw_input = 1'b1;                    // RL2
      end
      PH_REF: begin
        next_s.sw_ref_plus  = !next_s.pol;         // RL6 RL2
        next_s.sw_ref_minus = next_s.pol;          // RL6 RL2
        next_s.sw_loop      = 1'b1;
      end
      PH_INT_ZERO: begin
        next_s.sw_loop     = 1'b1;                 // RL2
        next_s.sw_int_zero = 1'b1;
      end
      default: begin
        // Hold keeps auto-zero running so the capacitor stays refreshed
        next_s.sw_zeroing    = 1'b1;               // RL3
        next_s.sw_ref_charge = 1'b1;
        next_s.sw_loop       = 1'b1;
      end
    endcase
  end

  // Reset enters a commanded auto-zero with the zeroing switches closed
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s               <= '0;
      s.phase         <= PH_SYS_ZERO;
      s.commanded     <= 1'b1;
      s.sw_zeroing    <= 1'b1;
      s.sw_ref_charge <= 1'b1;
      s.sw_loop       <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs, all registered
  assign input_switch            = s.sw_input;
  assign ref_plus_switch         = s.sw_ref_plus;
  assign ref_minus_switch        = s.sw_ref_minus;
  assign zeroing_switch          = s.sw_zeroing;
  assign reference_charge_switch = s.sw_ref_charge;
  assign integrator_loop_switch  = s.sw_loop;
  assign integrator_zero_switch  = s.sw_int_zero;
  assign busy                    = s.busy;
  assign overrange               = s.over;
  assign polarity                = s.pol;
  assign digit_select            = scan_bus.digit_sel;  // Bit 4 top digit, bit 0 least
  assign bcd                     = scan_bus.bcd;        // Bit 3 is the eight bit
  assign strobe_n                = scan_bus.strobe_n;

endmodule // dual_slope_adc_sequencer

`default_nettype wire

// [rtl/run_hold_filter.sv]
`timescale 1ns/10ps
`default_nettype none

module run_hold_filter (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic run_hold,
  output var  logic run_level,
  output var  logic run_pulse
);
  import adc_seq_pkg::*;

  typedef struct packed {
    logic [RUN_CNT_W-1:0] cnt;
    logic                 level;
    logic                 pulse;
  } filt_state_t;

  filt_state_t s;
  filt_state_t next_s;

  ////////////////////////////////////////////////////////////////////////////////
  // Width counter; a glitch shorter than the run width never fires the pulse
  always_comb begin
    next_s       = s;
    next_s.level = run_hold;
    next_s.pulse = run_hold && (s.cnt == RUN_CNT_W'(RUN_PULSE_CLKS - 1));  // RL11
    if (!run_hold) begin
      next_s.cnt = '0;
    end else if (s.cnt != RUN_CNT_W'(RUN_PULSE_CLKS)) begin
      next_s.cnt = s.cnt + RUN_CNT_W'(1);  // Saturates so one pulse per high period
    end
  end

  // Reset reads the line as high, as an open pin would
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s       <= '0;
      s.level <= 1'b1;  // RL9
    end else begin
      s <= next_s;
    end
  end

  assign run_level = s.level;
  assign run_pulse = s.pulse;

endmodule // run_hold_filter

`default_nettype wire

// [rtl/scan_if.sv]
`timescale 1ns/10ps
`default_nettype none

// Carries a finished reading from the sequencer to the digit scanner
interface scan_if;
  logic        load;       // One cycle at measurement end
  logic [19:0] reading;    // Five BCD digits, top digit in the high nibble
  logic        over;       // Reading is overrange
  logic        resume;     // Reference integration started
  logic [4:0]  digit_sel;  // Bit 4 is the top digit
  logic [3:0]  bcd;
  logic        strobe_n;

  modport seq  (output load, reading, over, resume, input digit_sel, bcd, strobe_n);
  modport scan (input load, reading, over, resume, output digit_sel, bcd, strobe_n);
endinterface

`default_nettype wire

// [sim/digit_latch_model.sv]
`timescale 1ns/10ps
`default_nettype none

// Stands in for the latch or processor that collects the five digits
module digit_latch_model (
  input  wire logic        clk_sys,
  input  wire logic        strobe_n,
  input  wire logic [3:0]  bcd,
  output var  logic [19:0] word,
  output var  int          count
);
  initial begin
    word  = 20'h00000;
    count = 0;
  end

  // Takes each digit on a low strobe, top digit first
  always @(posedge clk_sys) begin
    if (strobe_n === 1'b0) begin
      word  <= {word[15:0], bcd};
      count <= count + 1;
    end
  end
endmodule // digit_latch_model

`default_nettype wire

// [sim/dual_slope_adc_sequencer_monitor.sv]
`timescale 1ns/10ps
`default_nettype none

module dual_slope_adc_sequencer_monitor
  import adc_seq_pkg::*;
#(
  parameter int unsigned INPUT_LEN   = INPUT_INT_CLKS,
  parameter int unsigned IZ_OVER_LEN = IZ_OVER_CLKS
) (
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic       integrator_at_zero,
  input wire logic       input_positive,
  input wire logic       input_switch,
  input wire logic       ref_plus_switch,
  input wire logic       ref_minus_switch,
  input wire logic       zeroing_switch,
  input wire logic       reference_charge_switch,
  input wire logic       integrator_loop_switch,
  input wire logic       integrator_zero_switch,
  input wire logic       busy,
  input wire logic       overrange,
  input wire logic       polarity,
  input wire logic [4:0] digit_select,
  input wire logic [3:0] bcd,
  input wire logic       strobe_n
);
  //////////////////////////////////////////////////////////////////////////////
  // Run lengths, one clock behind, so a phase end sees the full count
  logic [15:0] in_cnt, iz_cnt, sel_cnt;
  logic [4:0]  prev_sel;
  wire  logic  ref_on = ref_plus_switch | ref_minus_switch;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      in_cnt   <= '0;
      iz_cnt   <= '0;
      sel_cnt  <= '0;
      prev_sel <= '0;
    end else begin
      in_cnt   <= input_switch ? in_cnt + 16'h1 : '0;
      iz_cnt   <= integrator_zero_switch ? iz_cnt + 16'h1 : '0;
      // Restarts at measurement end, the top select may already be up
      sel_cnt  <= $fell(busy) ? '0 : (digit_select != prev_sel) ? 16'h1 : sel_cnt + 16'h1;
      prev_sel <= digit_select;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // One clock domain: default clock and reset
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_meas_end;
    $fell(busy);
  endsequence

  sequence s_strobe;
    $fell(strobe_n) ##1 strobe_n;
  endsequence

  sequence s_top_digit;
    digit_select == SEL_TOP ##200 digit_select == SEL_TOP ##1 digit_select != SEL_TOP;
  endsequence

  a_input_alone: assert property (
    input_switch |-> !(zeroing_switch || reference_charge_switch || integrator_loop_switch
                      || integrator_zero_switch || ref_on))
    else $error("input switch not alone");
  a_zero_pattern: assert property (
    zeroing_switch |-> reference_charge_switch && integrator_loop_switch && !input_switch
                       && !ref_on && !integrator_zero_switch)
    else $error("system zero switch pattern wrong");
  a_ref_select: assert property (
    ref_on |-> integrator_loop_switch && ref_minus_switch == polarity
               && ref_plus_switch != polarity && !zeroing_switch)
    else $error("reference switch does not oppose polarity");
  a_input_length: assert property (
    $fell(input_switch) |-> in_cnt == 16'(INPUT_LEN))
    else $error("input integration length wrong");
  a_busy_start: assert property (
    $rose(busy) == $rose(input_switch))
    else $error("busy rise not at input start");
  a_polarity_latch: assert property (
    $fell(input_switch) |-> ref_on && polarity == $past(input_positive))
    else $error("polarity not latched at input end");
  a_polarity_hold: assert property (
    $changed(polarity) |-> $fell(input_switch))
    else $error("polarity changed outside reference start");
  a_ref_exit: assert property (
    ref_on && integrator_at_zero |=> !busy && !ref_on && integrator_zero_switch && !overrange)
    else $error("no exit on zero crossing");
  a_busy_fall: assert property (
    s_meas_end |-> integrator_zero_switch && !ref_on)
    else $error("busy fell outside integrator zero entry");
  a_izero_length: assert property (
    $fell(integrator_zero_switch) |->
      iz_cnt == (overrange ? 16'(IZ_OVER_LEN) : 16'(IZ_NORMAL_CLKS)) && zeroing_switch)
    else $error("integrator zero length wrong");
  a_over_set: assert property (
    $rose(overrange) |-> s_meas_end)
    else $error("overrange set away from busy fall");
  a_over_clear: assert property (
    $rose(ref_on) |-> !overrange)
    else $error("overrange not cleared at reference start");
  a_top_digit: assert property (
    s_meas_end |=> s_top_digit)
    else $error("top digit select timing wrong");
  a_first_strobe: assert property (
    s_meas_end |-> ##101 s_strobe)
    else $error("first strobe not 101 clocks after end");
  a_strobe_centre: assert property (
    $fell(strobe_n) |-> sel_cnt == 16'h0064 && digit_select != 5'h00)
    else $error("strobe not 100 clocks into select");
  a_digit_width: assert property (
    $changed(digit_select) && $past(digit_select) != 5'h00 && $past(digit_select) != SEL_TOP
    && digit_select != SEL_TOP |-> sel_cnt == 16'h00C8)
    else $error("digit select width wrong");
  a_bcd_blank: assert property (
    overrange || digit_select == 5'h00 |-> bcd == 4'h0)
    else $error("digit bits not blanked");
endmodule // dual_slope_adc_sequencer_monitor

bind dual_slope_adc_sequencer dual_slope_adc_sequencer_monitor #(
  .INPUT_LEN  (INPUT_LEN),
  .IZ_OVER_LEN(IZ_OVER_LEN)
) u_monitor (
  .clk_sys, .rst_n, .integrator_at_zero, .input_positive, .input_switch,
  .ref_plus_switch, .ref_minus_switch, .zeroing_switch, .reference_charge_switch,
  .integrator_loop_switch, .integrator_zero_switch, .busy, .overrange, .polarity,
  .digit_select, .bcd, .strobe_n
);

`default_nettype wire

// [sim/test_dual_slope_adc_sequencer.sv]
`timescale 1ns/10ps
`default_nettype none

`define CHECK(what, exp, got) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
      fails++; \
      $display("ERROR %s expected %0h seen %0h", what, exp, got); \
    end \
  end

module test_dual_slope_adc_sequencer;
  import adc_seq_pkg::*;

  localparam int T_CYCLE = 400;
  localparam int T_AZ    = 101;
  localparam int LIMIT   = 20000;  // Run needs about 6500 clocks

  logic        clk_sys, rst_n, run_hold, integrator_at_zero, input_positive;
  logic        input_switch, ref_plus_switch, ref_minus_switch, zeroing_switch;
  logic        reference_charge_switch, integrator_loop_switch, integrator_zero_switch;
  logic        busy, overrange, polarity, strobe_n;
  logic [4:0]  digit_select;
  logic [3:0]  bcd;
  logic [19:0] word, outs;
  logic        prev_in = 1'b0;
  int          fails = 0;
  int          num_checks = 0;
  int          cycles = 0, starts = 0, last_start = 0, prev_start = 0;
  int          count, c0, n;

  assign outs = {input_switch, ref_plus_switch, ref_minus_switch, zeroing_switch,
                 reference_charge_switch, integrator_loop_switch, integrator_zero_switch,
                 busy, overrange, polarity, strobe_n, digit_select, bcd};

  // Counts shortened so a conversion takes a few hundred clocks
  dual_slope_adc_sequencer #(
    .CYCLE_LEN(T_CYCLE), .INPUT_LEN(100), .AUTOZERO_LEN(T_AZ), .REF_MAX_LEN(201),
    .IZ_OVER_LEN(62)
  ) dut (
    .clk_sys, .rst_n, .run_hold, .integrator_at_zero, .input_positive, .input_switch,
    .ref_plus_switch, .ref_minus_switch, .zeroing_switch, .reference_charge_switch,
    .integrator_loop_switch, .integrator_zero_switch, .busy, .overrange, .polarity,
    .digit_select, .bcd, .strobe_n
  );

  digit_latch_model latch (.clk_sys, .strobe_n, .bcd, .word, .count);

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Clock count, hang limit and input start times
  always @(posedge clk_sys) begin
    cycles  <= cycles + 1;
    prev_in <= input_switch;
    if (input_switch === 1'b1 && prev_in === 1'b0) begin
      starts     <= starts + 1;
      prev_start <= last_start;
      last_start <= cycles;
    end
    if (cycles == LIMIT) begin
      fails++;
      finish_test();
    end
  end

  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
  endtask

  // Run pulse of w clocks; 61 is the shortest that exceeds 300 ns
  task automatic pulse(input int w);
    @(posedge clk_sys);
    run_hold <= 1'b1;
    tick(w);
    run_hold <= 1'b0;
  endtask

  // Comparator stand-in: crossing k clocks into reference, none when k is 0
  task automatic convert(input int k, input logic pos);
    input_positive <= pos;
    n = 0;
    while (input_switch !== 1'b1 && n < 3000) begin
      tick(1);
      n++;
    end
    while (ref_plus_switch !== 1'b1 && ref_minus_switch !== 1'b1 && n < 3000) begin
      tick(1);
      n++;
    end
    if (k > 0) begin
      tick(k - 1);
      integrator_at_zero <= 1'b1;
      tick(1);
      integrator_at_zero <= 1'b0;
    end
  endtask

  // Waits for busy to fall, then for one whole digit scan
  task automatic scan();
    n = 0;
    while (busy !== 1'b0 && n < 3000) begin
      tick(1);
      n++;
    end
    c0 = count;
    tick(1100);
  endtask

  function automatic logic [19:0] to_bcd(input int v);
    logic [19:0] r;
    for (int i = 0; i < 5; i++) begin
      r[i*4 +: 4] = 4'(v % 10);
      v = v / 10;
    end
    return r;
  endfunction

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Reset cycle, hold, single pulses, overrange, then continuous running
  initial begin
    rst_n              = 1'b0;
    run_hold           = 1'b1;
    integrator_at_zero = 1'b0;
    input_positive     = 1'b1;
    tick(4);
    rst_n <= 1'b1;
    tick(1);
    `CHECK("reset outputs", 20'h1C200, outs)
    run_hold <= 1'b0;
    n = 1;
    while (input_switch !== 1'b1 && n < 500) begin
      tick(1);
      n++;
    end
    `CHECK("autozero length", 1'b1, n >= T_AZ + 1 && n <= T_AZ + 2)
    convert(137, 1'b1);
    scan();
    `CHECK("digits", to_bcd(137), word)
    `CHECK("strobes", c0 + 5, count)
    `CHECK("polarity", 1'b1, polarity)
    `CHECK("held", 1, starts)
    tick(1100);
    `CHECK("refresh strobes", c0 + 5, count)
    `CHECK("refresh scan", 1'b1, digit_select != 5'h00)
    pulse(60);
    tick(300);
    `CHECK("short pulse", 1, starts)
    pulse(61);
    pulse(61);
    convert(1, 1'b0);
    scan();
    `CHECK("single cycle", 2, starts)
    `CHECK("digits", to_bcd(1), word)
    `CHECK("polarity", 1'b0, polarity)
    pulse(61);
    convert(0, 1'b1);
    scan();
    `CHECK("overrange", 1'b1, overrange)
    `CHECK("blank digits", 20'h00000, word)
    `CHECK("strobes", c0 + 5, count)
    `CHECK("scan stopped", 5'h00, digit_select)
    @(posedge clk_sys);
    run_hold <= 1'b1;
    convert(20, 1'b1);
    `CHECK("overrange cleared", 1'b0, overrange)
    convert(20, 1'b1);
    `CHECK("cycle spacing", T_CYCLE, last_start - prev_start)
    finish_test();
  end
endmodule // test_dual_slope_adc_sequencer

`default_nettype wire
